// file: rtl/pgr_pkg.sv
package pgr_pkg;

   // ****************************************************************
   // Register map.
   // ****************************************************************
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 32;
   localparam logic [15:0] OFF_STATUS_LOW  = 16'h1de0;
   localparam logic [15:0] OFF_STATUS_HIGH = 16'h1de4;
   localparam logic [15:0] OFF_DISABLE_ONE = 16'h1e20;
   localparam logic [15:0] OFF_DISABLE_TWO = 16'h1e24;

   // ****************************************************************
   // Implemented bits and field positions.
   // ****************************************************************
   localparam logic [31:0] STATUS_LOW_MASK  = 32'hfe1b_5ffc;
   localparam logic [31:0] STATUS_HIGH_MASK = 32'h1c78_00f7;
   localparam int unsigned USB_HOST_BIT     = 3;
   localparam int unsigned STORAGE_BIT      = 8;
   localparam int unsigned WIRELESS_BIT     = 19;
   localparam int unsigned LOCK_BIT         = 31;
   localparam int unsigned SENSOR_HUB_BIT   = 5;
   localparam int unsigned CONNECTIVITY_BIT = 1;
   localparam int unsigned NETWORK_BIT      = 0;
   localparam int unsigned DISABLE_TWO_W    = 12;

   // ****************************************************************
   // Reset values.
   // ****************************************************************
   localparam logic [31:0] STATUS_RESET      = 32'h0000_0000;
   localparam logic        LOCK_RESET        = 1'h0;
   localparam logic        DISABLE_BIT_RESET = 1'h0;
   localparam logic [11:0] DISABLE_TWO_RESET = 12'h000;
   localparam logic [31:0] READ_IDLE         = 32'h0000_0000;

   // ****************************************************************
   // Register port request.
   // ****************************************************************
   typedef struct packed {
      logic              valid;
      logic              write;
      logic [15:0]       addr;
      logic [31:0]       wdata;
   } pgr_req_t;

endpackage

// file: rtl/pgr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pgr_sync #(
   parameter int unsigned WIDTH = 32
) (
   // Clock and reset.
   input  wire logic             clock,
   input  wire logic             nrst,
   // Asynchronous levels in, settled levels out.
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // ****************************************************************
   // Three stage chain; a change counts once stages two and three agree.
   // ****************************************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sync_out <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               sync_out[i] <= s3_q[i];
            end
         end
      end
   end

endmodule

`default_nettype wire

// file: rtl/pgr_regs.sv
// Overview of operation
// - Low status bit: 0 gate, 1 power-on.
// - High status bit: 0 may gate, 1 not.
// - Low status fixed agent positions, reserved holes.
// - High status wireless bit 19, audio 28:26.
// - Lock bit 31 blocks lockable disable writes.
// - Writing 1 sets lock, self-locking.
// - Only resume-well reset clears the lock.
// - RTC-well reset clears sensor-hub disable bit 5.
// - RTC-well reset clears network disable bit 0.
// - Disable registers reset zero, reserved read-only.
`timescale 1ns/1ps
`default_nettype none

module pgr_regs (
   // Clock and resets.
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic             resume_well_reset_n,
   input  wire logic             rtc_well_reset_n,
   // Register port.
   input  wire pgr_pkg::pgr_req_t reg_req,
   output logic                  reg_ack,
   output logic      [31:0]      reg_rdata,
   // Agent request lines.
   input  wire logic [31:0]      gate_request_low,
   input  wire logic [31:0]      gate_request_high,
   // Disable controls to the agents.
   output logic                  disable_regs_lock,
   output logic                  sensor_hub_disable,
   output logic                  connectivity_disable,
   output logic                  network_ctrl_disable,
   output logic      [11:0]      serial_disable
);

   logic [31:0] status_low_s;
   logic [31:0] status_high_s;
   logic [31:0] status_low;
   logic [31:0] status_high;
   logic        lock_q;
   logic        sensor_q;
   logic        network_q;
   logic        connect_q;
   logic [11:0] disable_two_q;
   logic        wr_one;
   logic        wr_two;
   logic        rd_sel_ok;
   logic [31:0] rdata_d;
   logic [31:0] disable_one_view;

   // ****************************************************************
   // Agent request lines.
   // ****************************************************************
   pgr_sync #(
      .WIDTH    (32)
   ) u_sync_low (
      .clock    (clock),
      .nrst     (nrst),
      .async_in (gate_request_low),
      .sync_out (status_low_s)
   );

   pgr_sync #(
      .WIDTH    (32)
   ) u_sync_high (
      .clock    (clock),
      .nrst     (nrst),
      .async_in (gate_request_high),
      .sync_out (status_high_s)
   );

   assign status_low  = status_low_s & pgr_pkg::STATUS_LOW_MASK;
   assign status_high = status_high_s & pgr_pkg::STATUS_HIGH_MASK;

   // ****************************************************************
   // Write decode.
   // ****************************************************************
   // locked writes dropped
   assign wr_one = reg_req.valid && reg_req.write && !lock_q &&
                   (reg_req.addr == pgr_pkg::OFF_DISABLE_ONE);
   assign wr_two = reg_req.valid && reg_req.write && !lock_q &&
                   (reg_req.addr == pgr_pkg::OFF_DISABLE_TWO);

   // ****************************************************************
   // Lock bit.
   // ****************************************************************
   // self setting lock
   always_ff @(posedge clock or negedge resume_well_reset_n) begin
      if (!resume_well_reset_n) begin
         lock_q <= pgr_pkg::LOCK_RESET;
      end else if (wr_one && reg_req.wdata[pgr_pkg::LOCK_BIT]) begin
         lock_q <= 1'h1;
      end
   end

   // ****************************************************************
   // Real-time-clock well disable bits.
   // ****************************************************************
   // rtc well clear
   always_ff @(posedge clock or negedge rtc_well_reset_n) begin
      if (!rtc_well_reset_n) begin
         sensor_q  <= pgr_pkg::DISABLE_BIT_RESET;
         network_q <= pgr_pkg::DISABLE_BIT_RESET;
      end else if (wr_one) begin
         sensor_q  <= reg_req.wdata[pgr_pkg::SENSOR_HUB_BIT];
         network_q <= reg_req.wdata[pgr_pkg::NETWORK_BIT];
      end
   end

   // ****************************************************************
   // Core well disable bits.
   // ****************************************************************
   // zero after reset
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         connect_q     <= pgr_pkg::DISABLE_BIT_RESET;
         disable_two_q <= pgr_pkg::DISABLE_TWO_RESET;
      end else begin
         if (wr_one) begin
            connect_q <= reg_req.wdata[pgr_pkg::CONNECTIVITY_BIT];
         end
         if (wr_two) begin
            disable_two_q <= reg_req.wdata[pgr_pkg::DISABLE_TWO_W-1:0];
         end
      end
   end

   // ****************************************************************
   // Read path.
   // ****************************************************************
   always_comb begin
      disable_one_view = '0;
      disable_one_view[pgr_pkg::LOCK_BIT]         = lock_q;
      disable_one_view[pgr_pkg::SENSOR_HUB_BIT]   = sensor_q;
      disable_one_view[pgr_pkg::CONNECTIVITY_BIT] = connect_q;
      disable_one_view[pgr_pkg::NETWORK_BIT]      = network_q;
   end

   always_comb begin
      rdata_d   = pgr_pkg::READ_IDLE;
      rd_sel_ok = 1'h1;
      unique case (reg_req.addr)
         pgr_pkg::OFF_STATUS_LOW: begin
            rdata_d = status_low;
         end
         pgr_pkg::OFF_STATUS_HIGH: begin
            rdata_d = status_high;
         end
         pgr_pkg::OFF_DISABLE_ONE: begin
            rdata_d = disable_one_view;
         end
         pgr_pkg::OFF_DISABLE_TWO: begin
            rdata_d = {20'h0_0000, disable_two_q};
         end
         default: begin
            rd_sel_ok = 1'h0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         reg_ack   <= 1'h0;
         reg_rdata <= pgr_pkg::READ_IDLE;
      end else begin
         reg_ack <= reg_req.valid;
         if (reg_req.valid && !reg_req.write && rd_sel_ok) begin
            reg_rdata <= rdata_d;
         end else if (reg_req.valid) begin
            reg_rdata <= pgr_pkg::READ_IDLE;
         end
      end
   end

   // ****************************************************************
   // Disable controls.
   // ****************************************************************
   assign disable_regs_lock    = lock_q;
   assign sensor_hub_disable   = sensor_q;
   assign connectivity_disable = connect_q;
   assign network_ctrl_disable = network_q;
   assign serial_disable       = disable_two_q;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   lock_stays_set_a: assert property (
      @(posedge clock) disable iff (!resume_well_reset_n)
      lock_q |=> lock_q ##1 lock_q)
      else $error("lock bit fell without resume-well reset");

   lock_sets_a: assert property (
      @(posedge clock) disable iff (!resume_well_reset_n)
      (reg_req.valid && reg_req.write && reg_req.addr == pgr_pkg::OFF_DISABLE_ONE
       && reg_req.wdata[pgr_pkg::LOCK_BIT]) |=> disable_regs_lock)
      else $error("writing one did not set the lock");

   locked_write_a: assert property (
      @(posedge clock) disable iff (!nrst || !rtc_well_reset_n)
      (lock_q && reg_req.valid && reg_req.write)
      |=> $stable(serial_disable) && $stable(sensor_hub_disable)
          && $stable(connectivity_disable) && $stable(network_ctrl_disable))
      else $error("locked disable register changed on write");

   open_write_a: assert property (
      @(posedge clock) disable iff (!nrst)
      (!lock_q && reg_req.valid && reg_req.write
       && reg_req.addr == pgr_pkg::OFF_DISABLE_TWO)
      |=> serial_disable == $past(reg_req.wdata[11:0]))
      else $error("unlocked write to second disable register lost");

   low_read_a: assert property (
      @(posedge clock) disable iff (!nrst)
      (reg_req.valid && !reg_req.write && reg_req.addr == pgr_pkg::OFF_STATUS_LOW)
      |=> reg_ack && reg_rdata == ($past(status_low_s) & pgr_pkg::STATUS_LOW_MASK))
      else $error("low status read mismatch");

   high_read_a: assert property (
      @(posedge clock) disable iff (!nrst)
      (reg_req.valid && !reg_req.write && reg_req.addr == pgr_pkg::OFF_STATUS_HIGH)
      |=> reg_ack && (reg_rdata & ~pgr_pkg::STATUS_HIGH_MASK) == 32'h0000_0000)
      else $error("high status reserved bits not zero");

   one_reserved_a: assert property (
      @(posedge clock) disable iff (!nrst)
      (reg_req.valid && !reg_req.write && reg_req.addr == pgr_pkg::OFF_DISABLE_ONE)
      |=> (reg_rdata & 32'h7fff_ffdc) == 32'h0000_0000)
      else $error("first disable register reserved bits not zero");

   rtc_clear_a: assert property (
      @(posedge clock) !rtc_well_reset_n |-> !sensor_hub_disable && !network_ctrl_disable)
      else $error("rtc-well reset did not clear disable bits");

   status_write_a: assert property (
      @(posedge clock) disable iff (!nrst)
      (reg_req.valid && reg_req.write && reg_req.addr == pgr_pkg::OFF_STATUS_LOW)
      |=> $stable(serial_disable) && $stable(disable_regs_lock))
      else $error("status write disturbed state");

   lock_set_c: cover property (@(posedge clock) $rose(lock_q));
   locked_try_c: cover property (@(posedge clock) lock_q && reg_req.valid && reg_req.write);
   rtc_reset_c: cover property (@(posedge clock) nrst && !rtc_well_reset_n);

endmodule

`default_nettype wire

// file: test/pgr_agent_model.sv
`timescale 1ns/1ps
`default_nettype none

module pgr_agent_model (
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        nrst,
   // Levels ordered by the bench.
   input  wire logic [31:0] want_low,
   input  wire logic [31:0] want_high,
   // Request levels toward the block.
   output logic      [31:0] gate_request_low,
   output logic      [31:0] gate_request_high
);

   // ****************************************************************
   // Agent request levels.
   // ****************************************************************
   // Each agent drives its level from its own flop, all reserved places included.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         gate_request_low  <= 32'h0000_0000;
         gate_request_high <= 32'h0000_0000;
      end else begin
         gate_request_low  <= want_low;
         gate_request_high <= want_high;
      end
   end

endmodule

`default_nettype wire

// file: test/pg_request_status_and_fdis_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module pg_request_status_and_fdis_regs_tb_top;

   logic              clock = 1'b0;
   logic              nrst;
   logic              rsm_n;
   logic              rtc_n;
   pgr_pkg::pgr_req_t reg_req;
   logic              reg_ack;
   logic       [31:0] reg_rdata;
   logic       [31:0] want_low;
   logic       [31:0] want_high;
   logic       [31:0] req_low;
   logic       [31:0] req_high;
   logic              lock;
   logic              hub;
   logic              conn;
   logic              net;
   logic       [11:0] ser;
   logic       [31:0] rd;
   logic       [31:0] one_exp = 32'h0;
   int                error_cnt = 0;
   int                num_checks = 0;

   always #12.5 clock = ~clock;

   pgr_agent_model agents (.clock(clock), .nrst(nrst), .want_low(want_low),
      .want_high(want_high), .gate_request_low(req_low), .gate_request_high(req_high));

   pgr_regs DUT (.clock(clock), .nrst(nrst), .resume_well_reset_n(rsm_n),
      .rtc_well_reset_n(rtc_n), .reg_req(reg_req), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
      .gate_request_low(req_low), .gate_request_high(req_high), .disable_regs_lock(lock),
      .sensor_hub_disable(hub), .connectivity_disable(conn), .network_ctrl_disable(net),
      .serial_disable(ser));

   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_req <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
      @(posedge clock);
      reg_req.valid <= 1'b0;
      #1;
      chk({31'h0, reg_ack}, 32'h1, "ack");
      rd = reg_rdata;
   endtask

   task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input string what);
      acc(1'b0, a, 32'h0);
      chk(rd, exp, what);
      if (a == pgr_pkg::OFF_DISABLE_ONE) one_exp = exp;
      chk({lock, 25'h0, hub, 3'h0, conn, net}, one_exp, "pins");
      if (a == pgr_pkg::OFF_DISABLE_TWO) chk({20'h0, ser}, exp, "ser pins");
   endtask

   task automatic pulse(input int which);
      @(posedge clock);
      if (which == 0) nrst <= 1'b0;
      else if (which == 1) rtc_n <= 1'b0;
      else rsm_n <= 1'b0;
      repeat (2) @(posedge clock);
      nrst  <= 1'b1;
      rtc_n <= 1'b1;
      rsm_n <= 1'b1;
   endtask

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic t_reset();
      rdchk(pgr_pkg::OFF_DISABLE_ONE, 32'h0, "one rst");
      rdchk(pgr_pkg::OFF_DISABLE_TWO, 32'h0, "two rst");
      rdchk(16'h1e28, 32'h0, "unmapped");
      $display("test reset done");
   endtask

   task automatic t_status();
      want_low  <= 32'hffff_ffff;
      want_high <= 32'hffff_ffff;
      repeat (6) @(posedge clock);
      rdchk(pgr_pkg::OFF_STATUS_LOW, 32'hfe1b_5ffc, "low all");
      rdchk(pgr_pkg::OFF_STATUS_HIGH, pgr_pkg::STATUS_HIGH_MASK, "high all");
      acc(1'b1, pgr_pkg::OFF_STATUS_LOW, 32'h0);
      rdchk(pgr_pkg::OFF_STATUS_LOW, 32'hfe1b_5ffc, "low kept");
      want_low  <= 32'h0000_0008;
      want_high <= 32'h0008_0000;
      repeat (6) @(posedge clock);
      rdchk(pgr_pkg::OFF_STATUS_LOW, 32'h0000_0008, "usb");
      rdchk(pgr_pkg::OFF_STATUS_HIGH, 32'h0008_0000, "wireless");
      $display("test status done");
   endtask

   task automatic t_write();
      acc(1'b1, pgr_pkg::OFF_DISABLE_ONE, 32'h7fff_ffff);
      rdchk(pgr_pkg::OFF_DISABLE_ONE, 32'h0000_0023, "one rsvd");
      acc(1'b1, pgr_pkg::OFF_DISABLE_TWO, 32'hffff_ffff);
      rdchk(pgr_pkg::OFF_DISABLE_TWO, 32'h0000_0fff, "two rsvd");
      chk({20'h0, ser}, 32'h0000_0fff, "ser pins");
      acc(1'b1, pgr_pkg::OFF_DISABLE_TWO, 32'h0000_05a5);
      $display("test write done");
   endtask

   task automatic t_lock();
      acc(1'b1, pgr_pkg::OFF_DISABLE_ONE, 32'h8000_0023);
      rdchk(pgr_pkg::OFF_DISABLE_ONE, 32'h8000_0023, "lock set");
      acc(1'b1, pgr_pkg::OFF_DISABLE_ONE, 32'h0000_0000);
      rdchk(pgr_pkg::OFF_DISABLE_ONE, 32'h8000_0023, "one locked");
      acc(1'b1, pgr_pkg::OFF_DISABLE_TWO, 32'h0000_0000);
      rdchk(pgr_pkg::OFF_DISABLE_TWO, 32'h0000_05a5, "two locked");
      pulse(0);
      rdchk(pgr_pkg::OFF_DISABLE_ONE, 32'h8000_0021, "core rst");
      rdchk(pgr_pkg::OFF_DISABLE_TWO, 32'h0, "two core rst");
      pulse(1);
      rdchk(pgr_pkg::OFF_DISABLE_ONE, 32'h8000_0000, "rtc rst");
      pulse(2);
      rdchk(pgr_pkg::OFF_DISABLE_ONE, 32'h0, "resume rst");
      acc(1'b1, pgr_pkg::OFF_DISABLE_ONE, 32'h0000_0021);
      rdchk(pgr_pkg::OFF_DISABLE_ONE, 32'h0000_0021, "unlocked");
      $display("test lock done");
   endtask

   // ****************************************************************
   // Run control.
   // ****************************************************************
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #(3000 * 25);
      error_cnt++;
      $display("wrong value at %0t: watchdog expired", $time);
      end_of_test();
   end

   initial begin
      nrst      = 1'b1;
      rsm_n     = 1'b1;
      rtc_n     = 1'b1;
      reg_req   = '0;
      want_low  = 32'h0;
      want_high = 32'h0;
      #1;
      nrst  = 1'b0;
      rsm_n = 1'b0;
      rtc_n = 1'b0;
      repeat (3) @(posedge clock);
      nrst  <= 1'b1;
      rsm_n <= 1'b1;
      rtc_n <= 1'b1;
      t_reset();
      t_status();
      t_write();
      t_lock();
      end_of_test();
   end

endmodule

`default_nettype wire
